// >>> src/dmairq_core.v
// interrupt gating, missed frame counters and buffer pointers of the dma
// assumes one 50 mhz clock, inputs synchronous to it, and a status
// register outside that holds the event flags
//
// Summary of operation
// R1: both resets clear every interrupt enable
// R2: bit 16 gates the normal events
// R3: bit 15 gates the abnormal events
// R4: early receive needs bit 14 and 16
// R5: early transmit needs bit 10 and 15
// R6: receive watchdog needs bit 9 and 15
// R7: receive halted needs bit 8 and 15
// R8: receive no buffer needs bit 7 and 15
// R9: receive done needs bit 6, paired with 16
// R10: transmit underflow needs bit 5 and 15
// R11: transmit no buffer needs bit 2 and 16
// R12: transmit halted needs bit 1 and 15
// R13: transmit done needs bit 0 and 16
// R14: no-buffer drops count, cleared by read
// R15: no-buffer count wrap flag, cleared by read
// R16: fifo-full drops count, cleared by read
// R17: fifo-full count wrap flag, cleared by read
// R18: transmit buffer pointer readable, zero after reset
// R19: receive buffer pointer readable, zero after reset
// R20: reserved enable bits read zero, ignore writes
// R21: no owned descriptor suspends receive, flags it
// R22: irq while any enabled, summary-enabled event
// R23: counters wrap, flag sticks, no count lost
//
// The plain strobed port was decided locally.
`default_nettype none
`include "dmairq_defs.vh"

module dmairq_core (
   // clock and reset
   input wire ref_clk_i,
   input wire srst_i,
   input wire soft_rst_i,
   // register port
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   // status flags from the status register
   input wire [14:0] dma_status_i,
   // receive descriptor engine
   input wire rx_start_i,
   input wire rx_stop_i,
   input wire rx_fetch_i,
   input wire rx_desc_owned_i,
   output reg rx_no_buffer_set_o,
   output wire rx_suspended_o,
   // frame drop events
   input wire rx_nobuf_drop_i,
   input wire rx_fifo_full_drop_i,
   // current buffer addresses
   input wire tx_ptr_load_i,
   input wire [31:0] tx_ptr_i,
   input wire rx_ptr_load_i,
   input wire [31:0] rx_ptr_i,
   // interrupt
   output reg irq_o,
   output reg normal_irq_o,
   output reg abnormal_irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // receive process states
   localparam [2:0] RXS_STOP = 3'b001;
   localparam [2:0] RXS_RUN = 3'b010;
   localparam [2:0] RXS_SUSP = 3'b100;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   reg [31:0] dma_irq_enable_reg;
   reg [31:0] tx_current_buffer_ptr;
   reg [31:0] rx_current_buffer_ptr;
   reg [2:0] rx_state;
   reg [2:0] next_rx_state;
   reg next_no_buffer_set;
   reg [31:0] next_rdata;
   wire any_rst;
   wire wr_ien;
   wire rd_miss;
   wire [14:0] normal_events;
   wire [14:0] abnormal_events;
   wire [31:0] missed_frame_counters;
   wire [31:0] pend_word;
   wire [15:0] no_buffer_miss_count;
   wire no_buffer_count_wrap;
   wire [10:0] rx_overrun_miss_count;
   wire overrun_count_wrap;

   ////////////////////////////////////////////////////////////////////////
   // gating of one event group by its own enables and summary enable
   function [14:0] dmairq_gate;
      input [14:0] status;
      input [31:0] enables;
      input [14:0] group;
      input summary;
      begin
         dmairq_gate = status & enables[14:0] & group & {15{summary}};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset and register decode
   assign any_rst = srst_i | soft_rst_i;
   assign wr_ien = reg_wr_i && (reg_addr_i == `DMAIRQ_OFF_IEN);
   assign rd_miss = reg_rd_i && (reg_addr_i == `DMAIRQ_OFF_MISS);

   ////////////////////////////////////////////////////////////////////////
   // interrupt enable register
   always @(posedge ref_clk_i) begin
      if (any_rst) begin
         dma_irq_enable_reg <= `DMAIRQ_IEN_RST; // [R1]
      end else if (wr_ien) begin
         // only the defined enables take the write
         dma_irq_enable_reg <= reg_wdata_i & `DMAIRQ_IEN_WMASK; // [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // normal group: transmit done, transmit no buffer, receive done, early
   // receive, each with its own enable and bit 16
   assign normal_events = dmairq_gate(dma_status_i, dma_irq_enable_reg,
      `DMAIRQ_NORMAL_MASK,
      dma_irq_enable_reg[`DMAIRQ_IEN_NORMAL]); // [R2] [R4] [R9] [R11] [R13]

   ////////////////////////////////////////////////////////////////////////
   // abnormal group: transmit halted, underflow, receive no buffer,
   // receive halted, watchdog, early transmit, each with bit 15
   assign abnormal_events = dmairq_gate(dma_status_i, dma_irq_enable_reg,
      `DMAIRQ_ABNORMAL_MASK, // [R8] [R10] [R12]
      dma_irq_enable_reg[`DMAIRQ_IEN_ABNORMAL]); // [R3] [R5] [R6] [R7]

   // bits 7, 5 and 1 of the abnormal group sit in the same mask
   // and share the abnormal summary enable

   ////////////////////////////////////////////////////////////////////////
   // interrupt request, one cycle behind the status flags
   always @(posedge ref_clk_i) begin
      if (any_rst) begin
         irq_o <= 1'b0;
         normal_irq_o <= 1'b0;
         abnormal_irq_o <= 1'b0;
      end else begin
         normal_irq_o <= |normal_events;
         abnormal_irq_o <= |abnormal_events;
         irq_o <= (|normal_events) | (|abnormal_events); // [R22]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive process state: an attempt that finds no owned descriptor
   // suspends the process; a later attempt that finds one resumes it
   always @* begin
      next_rx_state = rx_state;
      next_no_buffer_set = 1'b0;
      case (rx_state)
         RXS_STOP: begin
            if (rx_start_i) begin
               next_rx_state = RXS_RUN;
            end
         end
         RXS_RUN: begin
            if (rx_stop_i) begin
               next_rx_state = RXS_STOP;
            end else if (rx_fetch_i && !rx_desc_owned_i) begin
               next_rx_state = RXS_SUSP; // [R21]
               next_no_buffer_set = 1'b1; // [R21]
            end
         end
         RXS_SUSP: begin
            if (rx_stop_i) begin
               next_rx_state = RXS_STOP;
            end else if (rx_fetch_i && rx_desc_owned_i) begin
               next_rx_state = RXS_RUN;
            end
         end
         default: begin
            next_rx_state = RXS_STOP;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // receive state register and status set pulse
   always @(posedge ref_clk_i) begin
      if (any_rst) begin
         rx_state <= RXS_STOP;
         rx_no_buffer_set_o <= 1'b0;
      end else begin
         rx_state <= next_rx_state;
         rx_no_buffer_set_o <= next_no_buffer_set;
      end
   end

   assign rx_suspended_o = rx_state[2];

   ////////////////////////////////////////////////////////////////////////
   // missed frame counters, cleared as the register is read
   dmairq_miss_cnt #(
      .WIDTH(`DMAIRQ_NOBUF_W)
   ) u_nobuf_cnt (
      .ref_clk_i(ref_clk_i),
      .srst_i(any_rst),
      .inc_i(rx_nobuf_drop_i),
      .clr_i(rd_miss),
      .count_o(no_buffer_miss_count),
      .wrap_o(no_buffer_count_wrap)
   ); // [R14] [R15] [R23]

   dmairq_miss_cnt #(
      .WIDTH(`DMAIRQ_OVR_W)
   ) u_ovr_cnt (
      .ref_clk_i(ref_clk_i),
      .srst_i(any_rst),
      .inc_i(rx_fifo_full_drop_i),
      .clr_i(rd_miss),
      .count_o(rx_overrun_miss_count),
      .wrap_o(overrun_count_wrap)
   ); // [R16] [R17] [R23]

   ////////////////////////////////////////////////////////////////////////
   // counter register image, reserved top bits zero
   assign missed_frame_counters = {3'h0, overrun_count_wrap,
      rx_overrun_miss_count, no_buffer_count_wrap, no_buffer_miss_count};

   ////////////////////////////////////////////////////////////////////////
   // pending view: gated events, group summaries and receive state
   assign pend_word = {11'h000, rx_state, |abnormal_events,
      |normal_events, 1'b0, normal_events | abnormal_events};

   ////////////////////////////////////////////////////////////////////////
   // current buffer pointers, loaded by the descriptor engine
   always @(posedge ref_clk_i) begin
      if (any_rst) begin
         tx_current_buffer_ptr <= `DMAIRQ_PTR_RST; // [R18]
         rx_current_buffer_ptr <= `DMAIRQ_PTR_RST; // [R19]
      end else begin
         if (tx_ptr_load_i) begin
            tx_current_buffer_ptr <= tx_ptr_i; // [R18]
         end
         if (rx_ptr_load_i) begin
            rx_current_buffer_ptr <= rx_ptr_i; // [R19]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read multiplexer, unmapped offsets read zero
   always @* begin
      next_rdata = 32'h00000000;
      case (reg_addr_i)
         `DMAIRQ_OFF_IEN: begin
            next_rdata = dma_irq_enable_reg; // [R20]
         end
         `DMAIRQ_OFF_MISS: begin
            next_rdata = missed_frame_counters;
         end
         `DMAIRQ_OFF_TXPTR: begin
            next_rdata = tx_current_buffer_ptr; // [R18]
         end
         `DMAIRQ_OFF_RXPTR: begin
            next_rdata = rx_current_buffer_ptr; // [R19]
         end
         `DMAIRQ_OFF_PEND: begin
            next_rdata = pend_word;
         end
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // read data register: valid the cycle after the strobe, else zero
   always @(posedge ref_clk_i) begin
      if (any_rst) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
      end else begin
         reg_rdata_o <= 32'h00000000;
      end
   end

endmodule // dmairq_core

`default_nettype wire

// >>> src/dmairq_defs.vh
// constants of the dma interrupt enable, miss counter and pointer block
// assumes byte offsets on an 8-bit register address port
`ifndef DMAIRQ_DEFS_VH
`define DMAIRQ_DEFS_VH

// register offsets
`define DMAIRQ_OFF_IEN 8'h1c
`define DMAIRQ_OFF_MISS 8'h20
`define DMAIRQ_OFF_TXPTR 8'h50
`define DMAIRQ_OFF_RXPTR 8'h54
`define DMAIRQ_OFF_PEND 8'h58

// interrupt enable fields
`define DMAIRQ_IEN_NORMAL 16
`define DMAIRQ_IEN_ABNORMAL 15
`define DMAIRQ_IEN_RST 32'h00000000
`define DMAIRQ_IEN_WMASK 32'h0001c7e7

// status bit groups, bit 6 placed in the normal group
`define DMAIRQ_NORMAL_MASK 15'h4045
`define DMAIRQ_ABNORMAL_MASK 15'h07a2

// missed frame counter fields
`define DMAIRQ_NOBUF_LSB 0
`define DMAIRQ_NOBUF_MSB 15
`define DMAIRQ_NOBUF_WRAP 16
`define DMAIRQ_OVR_LSB 17
`define DMAIRQ_OVR_MSB 27
`define DMAIRQ_OVR_WRAP 28
`define DMAIRQ_NOBUF_W 16
`define DMAIRQ_OVR_W 11

// pending register fields
`define DMAIRQ_PEND_NSUM 16
`define DMAIRQ_PEND_ASUM 17
`define DMAIRQ_PEND_RXS_LSB 18
`define DMAIRQ_PEND_RXS_MSB 20

// pointer reset value
`define DMAIRQ_PTR_RST 32'h00000000

`endif

// >>> src/dmairq_miss_cnt.v
// saturating-free missed frame counter with sticky wrap flag
// assumes clr_i is the one-cycle read strobe of the counter register
`default_nettype none

module dmairq_miss_cnt #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire ref_clk_i,
   input wire srst_i,
   // events
   input wire inc_i,
   input wire clr_i,
   // state
   output reg [WIDTH-1:0] count_o,
   output reg wrap_o
);

   ////////////////////////////////////////////////////////////////////////
   // count, wrap and clear on read
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         count_o <= {WIDTH{1'b0}};
         wrap_o <= 1'b0;
      end else if (clr_i) begin
         // reader saw the old value, a new frame starts the next count
         count_o <= inc_i ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}}; // [R23]
         wrap_o <= 1'b0; // [R15] [R17]
      end else if (inc_i) begin
         count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1}; // [R14] [R16]
         if (&count_o) begin
            wrap_o <= 1'b1; // [R23]
         end
      end
   end

endmodule // dmairq_miss_cnt

`default_nettype wire

// >>> verification/dmairq_core_assertions.sv
// port checker of the dma interrupt gating and miss counter core
// assumes the core's own ports only; bound to every dmairq_core
`default_nettype none
`include "dmairq_defs.vh"

module dmairq_core_chk (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic soft_rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // events
   input wire logic [14:0] dma_status_i,
   input wire logic rx_fetch_i,
   input wire logic rx_desc_owned_i,
   input wire logic rx_no_buffer_set_o,
   input wire logic rx_suspended_o,
   input wire logic rx_nobuf_drop_i,
   input wire logic rx_fifo_full_drop_i,
   // interrupt
   input wire logic irq_o,
   input wire logic normal_irq_o,
   input wire logic abnormal_irq_o
);
   logic [31:0] ien;
   logic any_rst, nrm, abn, quiet;
   ////////////////////////////////////////////////////////////
   // shadow of the enable register, writable bits only
   always @(posedge ref_clk_i) begin
      if (any_rst) ien <= 32'h0;
      else if (reg_wr_i && reg_addr_i == `DMAIRQ_OFF_IEN)
         ien <= reg_wdata_i & `DMAIRQ_IEN_WMASK;
   end
   // gated group requests and idle counter inputs
   assign any_rst = srst_i | soft_rst_i;
   assign nrm = ien[16] & |(dma_status_i & ien[14:0] & `DMAIRQ_NORMAL_MASK);
   assign abn = ien[15] & |(dma_status_i & ien[14:0] & `DMAIRQ_ABNORMAL_MASK);
   assign quiet = !rx_nobuf_drop_i && !rx_fifo_full_drop_i;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (any_rst);
   property p_rst;
      $fell(any_rst) |-> !irq_o && !rx_suspended_o && reg_rdata_o == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear");
   property p_ien;
      reg_rd_i && reg_addr_i == `DMAIRQ_OFF_IEN |=> reg_rdata_o == ien;
   endproperty
   a_ien: assert property (p_ien) else $error("enable readback");
   property p_norm;
      1 |=> normal_irq_o == $past(nrm);
   endproperty
   a_norm: assert property (p_norm)
      else $error("normal group");
   property p_abn;
      1 |=> abnormal_irq_o == $past(abn);
   endproperty
   a_abn: assert property (p_abn)
      else $error("abnormal group");
   property p_irq;
      1 |=> irq_o == $past(nrm | abn);
   endproperty
   a_irq: assert property (p_irq) else $error("irq request");
   sequence s_crd;
      reg_rd_i && reg_addr_i == `DMAIRQ_OFF_MISS && quiet;
   endsequence
   property p_clr;
      s_crd ##1 s_crd |=> reg_rdata_o == 32'h0;
   endproperty
   a_clr: assert property (p_clr)
      else $error("counters kept");
   property p_nobuf;
      rx_no_buffer_set_o |-> rx_suspended_o && $past(rx_fetch_i)
         && !$past(rx_desc_owned_i);
   endproperty
   a_nobuf: assert property (p_nobuf) else $error("no buffer flag");
   property p_pulse;
      rx_no_buffer_set_o |=> !rx_no_buffer_set_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("flag not a pulse");
   // main scenarios reached
   c_irq: cover property (irq_o);
   c_sus: cover property (rx_no_buffer_set_o);
   c_clr: cover property (s_crd);
endmodule // dmairq_core_chk

bind dmairq_core dmairq_core_chk u_chk (.ref_clk_i(ref_clk_i),
   .srst_i(srst_i), .soft_rst_i(soft_rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .dma_status_i(dma_status_i),
   .rx_fetch_i(rx_fetch_i), .rx_desc_owned_i(rx_desc_owned_i),
   .rx_no_buffer_set_o(rx_no_buffer_set_o),
   .rx_suspended_o(rx_suspended_o), .rx_nobuf_drop_i(rx_nobuf_drop_i),
   .rx_fifo_full_drop_i(rx_fifo_full_drop_i), .irq_o(irq_o),
   .normal_irq_o(normal_irq_o), .abnormal_irq_o(abnormal_irq_o));
`default_nettype wire

// >>> verification/test_dma_irq_enable_and_counters.sv
// self-checking bench of the dma interrupt gating and miss counters
// assumes the core and its checker are compiled alongside
`default_nettype none
`include "dmairq_defs.vh"

module test_dma_irq_enable_and_counters;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0, srst_i = 1'b1, soft_rst_i = 1'b0;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, rx_start_i = 1'b0;
   logic rx_stop_i = 1'b0, rx_fetch_i = 1'b0, rx_desc_owned_i = 1'b0;
   logic rx_nobuf_drop_i = 1'b0, rx_fifo_full_drop_i = 1'b0;
   logic tx_ptr_load_i = 1'b0, rx_ptr_load_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h0;
   logic [14:0] dma_status_i = 15'h0;
   logic [31:0] reg_wdata_i = 32'h0, tx_ptr_i = 32'h0, rx_ptr_i = 32'h0;
   logic [31:0] reg_rdata_o;
   logic rx_no_buffer_set_o, rx_suspended_o, irq_o;
   logic normal_irq_o, abnormal_irq_o;
   int err_total = 0, checked = 0;
   // rows: event bit and whether it is in the normal group
   int ev_bit[10] = '{0, 1, 2, 5, 6, 7, 8, 9, 10, 14};
   bit ev_nrm[10] = '{1, 0, 1, 0, 1, 0, 0, 0, 0, 1};
   // per-row own enable, summary enable, expected {irq, normal, abnormal}
   logic [31:0] ow, sm;
   logic [2:0] xp;
   int bt;
   ////////////////////////////////////////////////////////////
   dmairq_core dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .soft_rst_i(soft_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .dma_status_i(dma_status_i),
      .rx_start_i(rx_start_i), .rx_stop_i(rx_stop_i),
      .rx_fetch_i(rx_fetch_i), .rx_desc_owned_i(rx_desc_owned_i),
      .rx_no_buffer_set_o(rx_no_buffer_set_o),
      .rx_suspended_o(rx_suspended_o), .rx_nobuf_drop_i(rx_nobuf_drop_i),
      .rx_fifo_full_drop_i(rx_fifo_full_drop_i),
      .tx_ptr_load_i(tx_ptr_load_i), .tx_ptr_i(tx_ptr_i),
      .rx_ptr_load_i(rx_ptr_load_i), .rx_ptr_i(rx_ptr_i), .irq_o(irq_o),
      .normal_irq_o(normal_irq_o), .abnormal_irq_o(abnormal_irq_o));
   // 50 mhz clock
   always #10 ref_clk_i = ~ref_clk_i;
   ////////////////////////////////////////////////////////////
   // compare, bus cycles, verdict
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", reg_rdata_o, exp);
   endtask
   task automatic ev(input logic [31:0] en, input int b, input logic [2:0] e);
      wr(`DMAIRQ_OFF_IEN, en);
      @(posedge ref_clk_i);
      dma_status_i <= 15'h1 << b;
      repeat (2) @(posedge ref_clk_i);
      dma_status_i <= 15'h0;
      #1 chk("irq", {irq_o, normal_irq_o, abnormal_irq_o}, e);
   endtask
   task conclude;
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #2000000;
      err_total++;
      conclude();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      rc(`DMAIRQ_OFF_IEN, 32'h0);
      rc(`DMAIRQ_OFF_PEND, 32'h00040000);
      foreach (ev_bit[i]) begin
         bt = ev_bit[i];
         ow = 32'h00000001 << bt;
         sm = ev_nrm[i] ? 32'h00010000 : 32'h00008000;
         xp = {1'b1, ev_nrm[i], !ev_nrm[i]};
         ev(ow | sm, bt, xp);
         ev(ow | (sm ^ 32'h00018000), bt, 3'b000);
         ev(`DMAIRQ_IEN_WMASK & ~ow, bt, 3'b000);
      end
      // pointers load and ignore writes, reserved enables, soft reset
      @(posedge ref_clk_i);
      tx_ptr_i <= 32'hcafe0010;
      rx_ptr_i <= 32'h5a5a0a00;
      tx_ptr_load_i <= 1'b1;
      rx_ptr_load_i <= 1'b1;
      @(posedge ref_clk_i);
      tx_ptr_load_i <= 1'b0;
      rx_ptr_load_i <= 1'b0;
      wr(`DMAIRQ_OFF_TXPTR, 32'h0);
      rc(`DMAIRQ_OFF_TXPTR, 32'hcafe0010);
      rc(`DMAIRQ_OFF_RXPTR, 32'h5a5a0a00);
      wr(`DMAIRQ_OFF_IEN, 32'hffffffff);
      rc(`DMAIRQ_OFF_IEN, `DMAIRQ_IEN_WMASK);
      @(posedge ref_clk_i);
      soft_rst_i <= 1'b1;
      @(posedge ref_clk_i);
      soft_rst_i <= 1'b0;
      rc(`DMAIRQ_OFF_IEN, 32'h0);
      rc(`DMAIRQ_OFF_TXPTR, 32'h0);
      rc(`DMAIRQ_OFF_RXPTR, 32'h0);
      rc(8'h40, 32'h0);
      // both counters past their wrap, then two back-to-back reads
      @(posedge ref_clk_i);
      rx_nobuf_drop_i <= 1'b1;
      rx_fifo_full_drop_i <= 1'b1;
      repeat (2049) @(posedge ref_clk_i);
      rx_fifo_full_drop_i <= 1'b0;
      repeat (63488) @(posedge ref_clk_i);
      rx_nobuf_drop_i <= 1'b0;
      @(posedge ref_clk_i);
      reg_addr_i <= `DMAIRQ_OFF_MISS;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      #1 chk("miss", reg_rdata_o, 32'h10030001);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("miss", reg_rdata_o, 32'h0);
      // drop in the same cycle as the clearing read
      @(posedge ref_clk_i);
      reg_addr_i <= `DMAIRQ_OFF_MISS;
      reg_rd_i <= 1'b1;
      rx_nobuf_drop_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      rx_nobuf_drop_i <= 1'b0;
      #1 chk("miss", reg_rdata_o, 32'h0);
      rc(`DMAIRQ_OFF_MISS, 32'h1);
      // fetch without an owned descriptor, then resume
      @(posedge ref_clk_i);
      rx_start_i <= 1'b1;
      @(posedge ref_clk_i);
      rx_start_i <= 1'b0;
      rx_fetch_i <= 1'b1;
      @(posedge ref_clk_i);
      rx_desc_owned_i <= 1'b1;
      #1 chk("susp", {rx_suspended_o, rx_no_buffer_set_o}, 2'b11);
      @(posedge ref_clk_i);
      rx_fetch_i <= 1'b0;
      #1 chk("resume", {rx_suspended_o, rx_no_buffer_set_o}, 2'b00);
      rc(`DMAIRQ_OFF_PEND, 32'h00080000);
      // stop from running, state shows stopped again
      @(posedge ref_clk_i);
      rx_stop_i <= 1'b1;
      @(posedge ref_clk_i);
      rx_stop_i <= 1'b0;
      rc(`DMAIRQ_OFF_PEND, 32'h00040000);
      conclude();
   end
endmodule // test_dma_irq_enable_and_counters
`default_nettype wire
